// ==== hdl/sbm_fifo.sv ====
// Word FIFO between the register bus and the command/data lines.
// Assumes both sides on mclk; storage is a flip-flop array.
`timescale 1ns/1ps
module sbm_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  output logic      [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             doWr, doRd;

  assign inReady  = (cnt_r != (AW+1)'(DEPTH));
  assign outValid = (cnt_r != '0);
  assign outData  = mem_r[rdPtr_r];
  assign level    = cnt_r;
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  // ==========================================================
  // Pointers
  always_comb
  begin
    wrPtr_nxt = doWr ? wrPtr_r + AW'(1) : wrPtr_r;
    rdPtr_nxt = doRd ? rdPtr_r + AW'(1) : rdPtr_r;
    cnt_nxt   = cnt_r + (AW+1)'(doWr) - (AW+1)'(doRd);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r   <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (doWr)
      mem_r[wrPtr_r] <= inData;
  end
endmodule

// ==== hdl/sbm_master.sv ====
// System bus master signalling: request/grant, busy, command strobe,
// error mode with watchdog reset, breakpoint strobe, mode select.
// Assumes an AHB-Lite master on mclk and an external arbiter on pins.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module sbm_master
  import sbm_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Mode and debug
  input  wire logic        interface_mode_select,
  output logic             copyBackEn,
  output logic             storeBufMerge,
  output logic             breakpoint_strobe,
  output logic             error_mode_out,
  output logic             errorModeOe_n,
  output logic             watchdogReset,
  // Arbitration and busy
  output logic             bus_request_n,
  input  wire logic        bus_grant_n,
  input  wire logic        bus_busy_n_in,
  output logic             bus_busy_n_out,
  output logic             busBusyOe_n,
  // Command strobe and lines
  input  wire logic        command_strobe_n_in,
  output logic             command_strobe_n_out,
  output logic             commandStrobeOe_n,
  input  wire logic [63:0] cmd_data_lines_in,
  output logic      [63:0] cmd_data_lines_out,
  output logic             cmdDataOe_n,
  // Acknowledge and inhibit
  input  wire logic        ack_error_n,
  input  wire logic        ack_ready_n,
  input  wire logic        ack_retry_n,
  input  wire logic        memory_inhibit_n
);
  import sbm_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [5:0] pinRaw, pinSync;
  logic       grantN, busyN, ackEN, ackRN, ackTN, inhN;
  assign pinRaw = {bus_grant_n, bus_busy_n_in, ack_error_n,
                   ack_ready_n, ack_retry_n, memory_inhibit_n};
  sbm_sync #(.WIDTH(6), .INIT(6'h3F)) uSync (
    .mclk    (mclk),
    .rst     (rst),
    .pinIn   (pinRaw),
    .syncOut (pinSync)
  );
  assign {grantN, busyN, ackEN, ackRN, ackTN, inhN} = pinSync;
  logic [2:0] ackCode;
  assign ackCode = {ackEN, ackRN, ackTN};

  // Mode is caught once after reset release; it must not move later.
  logic modeHi_r, modeHi_nxt, modeCaught_r, modeCaught_nxt;

  // ==========================================================
  // Register bus
  logic        trapEn_r, trapEn_nxt, brk_r, brk_nxt;
  logic [SBM_CNT_W-1:0] datCnt_r, datCnt_nxt;
  logic [63:0] cmdWord_r, cmdWord_nxt, datStage_r, datStage_nxt;
  logic [2:0]  lastAck_r, lastAck_nxt;
  logic        start_r, start_nxt, excPulse;
  logic        aValid_r, aValid_nxt, aWrite_r, aWrite_nxt;
  logic [7:0]  aAddr_r, aAddr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
  logic [63:0] fifoOut;
  logic [$clog2(SBM_FIFO_D):0] fifoLevel;
  logic        errMode_r, errMode_nxt, inhSeen_r, inhSeen_nxt;
  logic [SBM_WDOG_W-1:0] wdog_r, wdog_nxt;
  sbm_state_t  st_r, st_nxt;

  function automatic logic isReg(input logic [7:0] a, input logic [7:0] r);
    isReg = (a == r);
  endfunction

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;
  assign excPulse  = aValid_r && aWrite_r && isReg(aAddr_r, SBM_CTRL_ADDR)
                     && hwdata[SBM_CTRL_EXC];
  assign fifoInValid = aValid_r && aWrite_r && isReg(aAddr_r, SBM_PUSH_ADDR);

  always_comb
  begin
    aValid_nxt = hsel && hready && htrans[1];
    aWrite_nxt = hwrite;
    aAddr_nxt  = haddr[7:0];
    trapEn_nxt = trapEn_r;
    brk_nxt    = brk_r;
    datCnt_nxt = datCnt_r;
    cmdWord_nxt = cmdWord_r;
    datStage_nxt = datStage_r;
    start_nxt  = start_r;
    rdata_nxt  = '0;
    if (st_r == SBM_REQ && !grantN && busyN)
      start_nxt = 1'b0;
    if (aValid_r && aWrite_r)
    begin
      unique case (aAddr_r)
        SBM_CTRL_ADDR:
        begin
          trapEn_nxt = hwdata[SBM_CTRL_TRAPEN];
          brk_nxt    = hwdata[SBM_CTRL_BRK];
          datCnt_nxt = hwdata[SBM_CTRL_DATCNT +: SBM_CNT_W];
        end
        SBM_CMD_LO_ADDR: cmdWord_nxt[31:0]  = hwdata;
        SBM_CMD_HI_ADDR: cmdWord_nxt[63:32] = hwdata;
        SBM_DAT_LO_ADDR: datStage_nxt[31:0] = hwdata;
        SBM_DAT_HI_ADDR: datStage_nxt[63:32] = hwdata;
        SBM_STATUS_ADDR: start_nxt = !errMode_r && modeHi_r;
        default: ;
      endcase
    end
    // A read address phase may overlap a write data phase.
    if (aValid_nxt && !hwrite)
    begin
      unique case (haddr[7:0])
        SBM_CTRL_ADDR: rdata_nxt = 32'({datCnt_r, 1'b0, brk_r, 1'b0,
                                        trapEn_r} << 0);
        SBM_STATUS_ADDR: rdata_nxt = 32'({fifoLevel, inhSeen_r,
                                          errMode_r, modeHi_r, start_r,
                                          st_r});
        SBM_CMD_LO_ADDR: rdata_nxt = cmdWord_r[31:0];
        SBM_CMD_HI_ADDR: rdata_nxt = cmdWord_r[63:32];
        SBM_ACK_ADDR:    rdata_nxt = 32'(lastAck_r);
        default:         rdata_nxt = '0;
      endcase
    end
  end

  sbm_fifo #(.WIDTH(SBM_WORD_W), .DEPTH(SBM_FIFO_D)) uFifo (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (datStage_r),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOut),
    .level    (fifoLevel)
  );

  // ==========================================================
  // Bus transaction sequencer
  logic [SBM_CNT_W-1:0] left_r, left_nxt;
  assign fifoOutReady = (st_r == SBM_DATA) && (ackCode == SBM_ACK_VALID);

  always_comb
  begin
    st_nxt      = st_r;
    left_nxt    = left_r;
    lastAck_nxt = lastAck_r;
    inhSeen_nxt = inhSeen_r || !inhN;
    unique case (st_r)
      SBM_IDLE:
        if (start_r && modeHi_r && !errMode_r)
          st_nxt = SBM_REQ;
      SBM_REQ:
        if (!grantN && busyN)
          st_nxt = SBM_CMD;
      SBM_CMD:
      begin
        st_nxt   = (datCnt_r == '0) ? SBM_ACK : SBM_DATA;
        left_nxt = datCnt_r;
      end
      SBM_DATA:
        if (ackCode != SBM_ACK_IDLE)
        begin
          lastAck_nxt = ackCode;
          if (ackCode != SBM_ACK_VALID || !fifoOutValid)
            st_nxt = SBM_IDLE;
          else if (left_r == SBM_CNT_W'(1))
            st_nxt = SBM_IDLE;
          else
            left_nxt = left_r - SBM_CNT_W'(1);
        end
      SBM_ACK:
        if (ackCode != SBM_ACK_IDLE)
        begin
          lastAck_nxt = ackCode;
          st_nxt      = SBM_IDLE;
        end
      default: st_nxt = SBM_IDLE;
    endcase
    if (errMode_r)
      st_nxt = SBM_IDLE;
  end

  // ==========================================================
  // Error mode, watchdog and mode latch
  always_comb
  begin
    errMode_nxt = errMode_r;
    wdog_nxt    = wdog_r;
    if (excPulse && !trapEn_r)
    begin
      errMode_nxt = 1'b1;
      wdog_nxt    = SBM_WDOG_W'(SBM_WDOG_CYC);
    end
    else if (errMode_r)
    begin
      wdog_nxt = wdog_r - SBM_WDOG_W'(1);
      if (wdog_r == SBM_WDOG_W'(1))
        errMode_nxt = 1'b0;
    end
    modeCaught_nxt = 1'b1;
    modeHi_nxt     = modeCaught_r ? modeHi_r : interface_mode_select;
  end

  always_ff @(posedge mclk)
  begin
    if (rst || watchdogReset)
    begin
      trapEn_r <= 1'b0;
      brk_r    <= 1'b0;
      datCnt_r <= '0;
      start_r  <= 1'b0;
      st_r     <= SBM_IDLE;
      left_r   <= '0;
      lastAck_r <= SBM_ACK_IDLE;
      inhSeen_r <= 1'b0;
    end
    else
    begin
      trapEn_r <= trapEn_nxt;
      brk_r    <= brk_nxt;
      datCnt_r <= datCnt_nxt;
      start_r  <= start_nxt;
      st_r     <= st_nxt;
      left_r   <= left_nxt;
      lastAck_r <= lastAck_nxt;
      inhSeen_r <= inhSeen_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      aValid_r     <= 1'b0;
      aWrite_r     <= 1'b0;
      aAddr_r      <= '0;
      rdata_r      <= '0;
      cmdWord_r    <= '0;
      datStage_r   <= '0;
      errMode_r    <= 1'b0;
      wdog_r       <= '0;
      modeHi_r     <= 1'b0;
      modeCaught_r <= 1'b0;
    end
    else
    begin
      aValid_r     <= aValid_nxt;
      aWrite_r     <= aWrite_nxt;
      aAddr_r      <= aAddr_nxt;
      rdata_r      <= rdata_nxt;
      cmdWord_r    <= cmdWord_nxt;
      datStage_r   <= datStage_nxt;
      errMode_r    <= errMode_nxt;
      wdog_r       <= wdog_nxt;
      modeHi_r     <= modeHi_nxt;
      modeCaught_r <= modeCaught_nxt;
    end
  end

  // ==========================================================
  // Pin drive
  assign watchdogReset        = errMode_r && (wdog_r == SBM_WDOG_W'(1));
  assign error_mode_out       = 1'b0;
  assign errorModeOe_n        = !errMode_r;
  assign copyBackEn           = modeHi_r;
  assign storeBufMerge        = modeHi_r;
  assign breakpoint_strobe    = brk_r;
  assign bus_request_n        = !(st_r == SBM_REQ);
  assign command_strobe_n_out = !(st_r == SBM_CMD);
  assign commandStrobeOe_n    = (st_r == SBM_IDLE) || (st_r == SBM_REQ);
  assign bus_busy_n_out       = 1'b0;
  assign busBusyOe_n          = commandStrobeOe_n;
  assign cmdDataOe_n          = !(st_r == SBM_CMD || st_r == SBM_DATA);
  assign cmd_data_lines_out   = (st_r == SBM_CMD) ? cmdWord_r : fifoOut;

  // ==========================================================
  // Checks
  a_no_start_ungranted: assert property (@(posedge mclk) disable iff (rst)
    $rose(st_r == SBM_CMD) |-> $past(!grantN && busyN))
    else $error("Command began without grant or while bus busy");
  sequence sReqGranted;
    st_r == SBM_REQ && !grantN && busyN && !errMode_r;
  endsequence
  a_grant_to_strobe: assert property (@(posedge mclk) disable iff (rst)
    sReqGranted |=> !command_strobe_n_out && !commandStrobeOe_n)
    else $error("Strobe did not follow grant");
  a_strobe_one_cycle: assert property (@(posedge mclk) disable iff (rst)
    !command_strobe_n_out |=> command_strobe_n_out)
    else $error("Command strobe held beyond one word");
  a_busy_during_txn: assert property (@(posedge mclk) disable iff (rst)
    (st_r == SBM_CMD || st_r == SBM_DATA) |-> !busBusyOe_n)
    else $error("Busy not driven during transaction");
  a_err_enter: assert property (@(posedge mclk) disable iff (rst)
    (excPulse && !trapEn_r && !errMode_r) |=> errorModeOe_n == 1'b0)
    else $error("Error mode not entered");
  a_err_release: assert property (@(posedge mclk) disable iff (rst)
    !errMode_r |-> errorModeOe_n)
    else $error("Error output driven outside error mode");
  a_wdog_length: assert property (@(posedge mclk) disable iff (rst)
    $rose(errMode_r) |-> ##9 watchdogReset)
    else $error("Watchdog reset not at expected cycle");
  a_request_idle: assert property (@(posedge mclk) disable iff (rst)
    (st_r == SBM_IDLE) |-> bus_request_n && commandStrobeOe_n)
    else $error("Bus outputs active while idle");
  a_breakpoint: assert property (@(posedge mclk) disable iff (rst)
    (aValid_r && aWrite_r && isReg(aAddr_r, SBM_CTRL_ADDR) && !watchdogReset)
    |=> breakpoint_strobe == $past(hwdata[SBM_CTRL_BRK]))
    else $error("Breakpoint strobe not following event");
endmodule

// ==== hdl/sbm_pkg.sv ====
// Shared constants for the system bus master signalling block.
// Assumes one 10 MHz clock mclk and an AHB-Lite register master.
package sbm_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] SBM_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] SBM_STATUS_ADDR = 8'h04;
  localparam logic [7:0] SBM_CMD_LO_ADDR = 8'h08;
  localparam logic [7:0] SBM_CMD_HI_ADDR = 8'h0C;
  localparam logic [7:0] SBM_DAT_LO_ADDR = 8'h10;
  localparam logic [7:0] SBM_DAT_HI_ADDR = 8'h14;
  localparam logic [7:0] SBM_ACK_ADDR    = 8'h18;
  localparam logic [7:0] SBM_PUSH_ADDR   = 8'h1C;
  // CTRL fields.
  localparam int SBM_CTRL_TRAPEN = 0;
  localparam int SBM_CTRL_EXC    = 1;
  localparam int SBM_CTRL_BRK    = 2;
  localparam int SBM_CTRL_DATCNT = 4;
  localparam int SBM_CNT_W       = 4;
  // Bus sizes.
  localparam int SBM_WORD_W = 64;
  localparam int SBM_FIFO_D = 8;
  // AHB codes.
  localparam logic [1:0] SBM_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] SBM_HTRANS_SEQ    = 2'h3;
  // Acknowledge codes, error/ready/retry levels.
  localparam logic [2:0] SBM_ACK_IDLE   = 3'h7;
  localparam logic [2:0] SBM_ACK_RELRTY = 3'h6;
  localparam logic [2:0] SBM_ACK_VALID  = 3'h5;
  localparam logic [2:0] SBM_ACK_RSVD   = 3'h4;
  localparam logic [2:0] SBM_ACK_BUSERR = 3'h3;
  localparam logic [2:0] SBM_ACK_TMOUT  = 3'h2;
  localparam logic [2:0] SBM_ACK_UNCORR = 3'h1;
  localparam logic [2:0] SBM_ACK_RETRY  = 3'h0;
  // Watchdog reset length.
  localparam int  SBM_WDOG_NS     = 1000;
  localparam int  SBM_CLK_NS      = 100;
  localparam int  SBM_WDOG_CYC    = (SBM_WDOG_NS + SBM_CLK_NS - 1) / SBM_CLK_NS;
  localparam int  SBM_WDOG_W      = 4;
  typedef enum logic [2:0] {
    SBM_IDLE = 3'b000,
    SBM_REQ  = 3'b001,
    SBM_CMD  = 3'b010,
    SBM_DATA = 3'b011,
    SBM_ACK  = 3'b100
  } sbm_state_t;
endpackage

// ==== hdl/sbm_sync.sv ====
// Three-flop synchroniser bank for pin inputs.
// A change counts once the second and third stage agree.
`timescale 1ns/1ps
module sbm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Pins and filtered result
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r, out_nxt;
  genvar g;

  // ==========================================================
  // Per-bit agreement filter
  generate
    for (g = 0; g < WIDTH; g++)
    begin : gBit
      always_comb
      begin
        out_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : out_r[g];
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s1_r  <= INIT;
      s2_r  <= INIT;
      s3_r  <= INIT;
      out_r <= INIT;
    end
    else
    begin
      s1_r  <= pinIn;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end
  assign syncOut = out_r;
endmodule

// ==== tb/sbm_arbiter_model.sv ====
// Arbiter and responding agent model for the master signalling bench.
// Assumes pins sampled on mclk; each acknowledge stands two cycles so
// the design's three-flop synchronisers see every one of them.
`timescale 1ns/1ps
module sbm_arbiter_model
  import sbm_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Settings from the bench
  input  wire logic [7:0] grantWait,
  input  wire logic [7:0] ackGap,
  input  wire logic [2:0] ackCode,
  input  wire logic       inhOn,
  // Bus pins
  input  wire logic       reqN,
  input  wire logic       busyN,
  output logic            grantN,
  output logic            errN,
  output logic            rdyN,
  output logic            rtyN,
  output logic            inhN
);
  logic [7:0] gCnt;
  logic [7:0] aCnt;
  // ==========================================================
  // Grant on a line of its own, low meaning granted.
  always_ff @(posedge mclk)
  begin
    if (rst || (reqN && busyN))
    begin
      gCnt   <= 8'h00;
      grantN <= 1'b1;
    end
    else if (!reqN)
    begin
      gCnt   <= gCnt + 8'h01;
      grantN <= !(gCnt >= grantWait);
    end
  end
  // ==========================================================
  // Acknowledge while the master holds the bus; idle otherwise.
  always_ff @(posedge mclk)
  begin
    if (rst || busyN)
      aCnt <= 8'h00;
    else
      aCnt <= (aCnt == ackGap + 8'h03) ? 8'h00 : aCnt + 8'h01;
    if (!rst && !busyN && (aCnt == ackGap || aCnt == ackGap + 8'h01))
      {errN, rdyN, rtyN} <= ackCode;
    else
      {errN, rdyN, rtyN} <= SBM_ACK_IDLE;
    inhN <= !(inhOn && !busyN && aCnt >= 8'h01 && aCnt <= 8'h03);
  end
endmodule

// ==== tb/system_bus_master_signalling_bench.sv ====
// Self-checking bench for the system bus master signalling block.
// Assumes the arbiter model on the far side and an AHB-Lite master here.
`timescale 1ns/1ps
module system_bus_master_signalling_bench;
  import sbm_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        modeSel = 1'b1;
  logic        holdBusyN = 1'b1;
  logic [7:0]  grantWait = 8'h05;
  logic [7:0]  ackGap = 8'h03;
  logic [2:0]  ackCode = SBM_ACK_VALID;
  logic        inhOn = 1'b0;
  logic        hreadyout, hresp, copyBackEn, storeBufMerge, brk, errOut;
  logic        errOeN, wdog, reqN, grantN, busyOut, busyOeN, strOut, strOeN;
  logic        linesOeN, errN, rdyN, rtyN, inhN;
  logic [31:0] hrdata;
  logic [63:0] linesOut, cmdSeen;
  logic [63:0] datQ[$];
  int          n_errors = 0;
  int          n_checks = 0;
  int          strCnt = 0;
  int          grRun = 0;
  int          freeRun = 0;
  // Released lines float up through pull-ups; data lines show noise.
  wire         uutBusy = busyOeN ? 1'b1 : busyOut;
  wire         busyPin = uutBusy & holdBusyN;
  wire         strPin = strOeN ? 1'b1 : strOut;
  wire         errPin = errOeN ? 1'b1 : errOut;
  wire  [63:0] linesPin = linesOeN ? ~linesOut : linesOut;
  always #50 mclk = ~mclk;
  sbm_master uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .interface_mode_select(modeSel),
    .copyBackEn(copyBackEn), .storeBufMerge(storeBufMerge),
    .breakpoint_strobe(brk), .error_mode_out(errOut),
    .errorModeOe_n(errOeN), .watchdogReset(wdog), .bus_request_n(reqN),
    .bus_grant_n(grantN), .bus_busy_n_in(busyPin),
    .bus_busy_n_out(busyOut), .busBusyOe_n(busyOeN),
    .command_strobe_n_in(strPin), .command_strobe_n_out(strOut),
    .commandStrobeOe_n(strOeN), .cmd_data_lines_in(linesPin),
    .cmd_data_lines_out(linesOut), .cmdDataOe_n(linesOeN),
    .ack_error_n(errN), .ack_ready_n(rdyN), .ack_retry_n(rtyN),
    .memory_inhibit_n(inhN));
  sbm_arbiter_model far (.mclk(mclk), .rst(rst), .grantWait(grantWait),
    .ackGap(ackGap), .ackCode(ackCode), .inhOn(inhOn), .reqN(reqN),
    .busyN(uutBusy), .grantN(grantN), .errN(errN), .rdyN(rdyN),
    .rtyN(rtyN), .inhN(inhN));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= SBM_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic doReset(input logic m);
    rst <= 1'b1;
    modeSel <= m;
    cyc(4);
    rst <= 1'b0;
    cyc(2);
  endtask
  task automatic waitFor(input logic [2:0] sel, input logic v);
    int k;
    logic [2:0] seen;
    k = 0;
    seen = {reqN, busyOeN, wdog};
    while (k < 1000 && seen[sel] !== v)
    begin
      cyc(1);
      k++;
      seen = {reqN, busyOeN, wdog};
    end
    if (k == 1000)
    begin
      n_errors++;
      $display("ERROR wait %0d expected %b seen %b", sel, v, seen[sel]);
    end
  endtask
  // Watch the strobe cycle, the command word and each data word.
  always @(posedge mclk)
  begin
    grRun = grantN ? 0 : grRun + 1;
    freeRun = holdBusyN ? freeRun + 1 : 0;
    if (!strPin)
    begin
      strCnt++;
      cmdSeen = linesPin;
      chk("busy at strobe", 64'h0, {63'h0, busyPin});
      chk("grant and free", 64'h1, {63'h0, grRun >= 3 && freeRun >= 3});
    end
    else if (!linesOeN && (datQ.size() == 0 || datQ[$] !== linesPin))
      datQ.push_back(linesPin);
  end
  // ==========================================================
  // Transfer helpers
  task automatic load(input int p);
    for (int i = 0; i < p; i++)
    begin
      wr(SBM_DAT_LO_ADDR, 32'h100 + i);
      wr(SBM_DAT_HI_ADDR, 32'hD0000000 + i);
      wr(SBM_PUSH_ADDR, 32'h0);
    end
  endtask
  task automatic go(input int n, input logic [2:0] code, input int hold);
    logic [31:0] q;
    ackCode <= code;
    strCnt = 0;
    datQ.delete();
    wr(SBM_CMD_LO_ADDR, 32'hC0DE0000 + n);
    wr(SBM_CMD_HI_ADDR, 32'h0A0B0C0D);
    wr(SBM_CTRL_ADDR, 32'(n << 4) | 32'h1);
    holdBusyN <= 1'b0;
    wr(SBM_STATUS_ADDR, 32'h1);
    waitFor(3'd2, 1'b0);
    chk("request low", 64'h0, {63'h0, reqN});
    cyc(hold);
    holdBusyN <= 1'b1;
    waitFor(3'd1, 1'b0);
    waitFor(3'd1, 1'b1);
    cyc(4);
    chk("strobe cycles", 64'h1, 64'(strCnt));
    chk("command word", {32'h0A0B0C0D, 32'hC0DE0000 + n}, cmdSeen);
    chk("idle outputs", 64'h7, {61'h0, reqN, busyOeN, strOeN});
    if (code == SBM_ACK_VALID)
      for (int i = 0; i < n; i++)
        chk("data word", {32'hD0000000 + i, 32'h100 + i}, datQ[i]);
    else
    begin
      xfer(SBM_ACK_ADDR, 1'b0, 32'h0, q);
      chk("ack code", 64'(code), 64'(q[2:0]));
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] q;
    chk("reset outputs", 64'h1F, {reqN, busyOeN, strOeN, linesOeN, errOeN});
    chk("breakpoint idle", 64'h0, {63'h0, brk});
    xfer(8'h40, 1'b0, 32'h0, q);
    chk("unmapped read", 64'h0, {31'h0, hresp, q});
    $display("test reset done");
  endtask
  task automatic t_mode;
    doReset(1'b0);
    chk("write-through", 64'h0, {62'h0, copyBackEn, storeBufMerge});
    wr(SBM_STATUS_ADDR, 32'h1);
    cyc(8);
    chk("no request", 64'h1, {63'h0, reqN});
    doReset(1'b1);
    chk("copy-back", 64'h3, {62'h0, copyBackEn, storeBufMerge});
    wr(SBM_CTRL_ADDR, 32'h4);
    cyc(1);
    chk("breakpoint on", 64'h1, {63'h0, brk});
    wr(SBM_CTRL_ADDR, 32'h0);
    cyc(1);
    chk("breakpoint off", 64'h0, {63'h0, brk});
    $display("test mode done");
  endtask
  task automatic t_transfer;
    logic [2:0] codes [5] = '{SBM_ACK_RELRTY, SBM_ACK_BUSERR,
                              SBM_ACK_TMOUT, SBM_ACK_UNCORR, SBM_ACK_RETRY};
    grantWait <= 8'h14;
    load(2);
    go(2, SBM_ACK_VALID, 12);
    grantWait <= 8'h05;
    for (int i = 0; i < 5; i++)
    begin
      // Grant comes while the bus is still busy; even turns send no data.
      load(1);
      go(i % 2, codes[i], 12);
    end
    $display("test transfer done");
  endtask
  task automatic t_fill;
    logic [31:0] q;
    doReset(1'b1);
    load(9);
    xfer(SBM_STATUS_ADDR, 1'b0, 32'h0, q);
    chk("fifo full", 64'h8, 64'(q[10:7]));
    ackGap <= 8'h08;
    inhOn <= 1'b1;
    go(8, SBM_ACK_VALID, 0);
    xfer(SBM_STATUS_ADDR, 1'b0, 32'h0, q);
    chk("empty and inhibit", 64'h1, 64'(q[10:6]));
    $display("test fill done");
  endtask
  task automatic t_error;
    wr(SBM_CTRL_ADDR, 32'h1);
    wr(SBM_CTRL_ADDR, 32'h3);
    cyc(3);
    chk("no error mode", 64'h1, {63'h0, errOeN});
    wr(SBM_CTRL_ADDR, 32'h0);
    wr(SBM_CTRL_ADDR, 32'h2);
    cyc(2);
    chk("error pin low", 64'h0, {63'h0, errPin});
    waitFor(3'd0, 1'b1);
    chk("watchdog reset", 64'h1, {63'h0, wdog});
    cyc(2);
    chk("error released", 64'h1, {63'h0, errOeN});
    $display("test error done");
  endtask
  // ==========================================================
  // Verdict and run
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #6000000;
    n_errors++;
    end_sim();
  end
  initial
  begin
    cyc(4);
    rst <= 1'b0;
    cyc(1);
    t_reset();
    t_mode();
    t_transfer();
    t_fill();
    t_error();
    end_sim();
  end
endmodule
